// ---- core/fbsio_station.sv ----
// cyclic slave station map: remote bit and word images with wishbone access
//
// What this block does
// [RULE1] bit image spans words n..n+1 for one station, n..n+7 for four
// [RULE2] ready flag unused: top two bits of last bit word are reserved
// [RULE3] ready flag used: bit B of last outgoing word, rest reserved
// [RULE4] ready flag rises once the station is operational after reset
// [RULE5] ready flag low while offline or during initial processing
// [RULE6] master exchanges data only while the ready flag is high; the master model waits for it only in put, if interlocked, up to 100 cycles
// [RULE7] outgoing word area: four words, or sixteen with four stations
// [RULE8] incoming word area: four words, or sixteen with four stations
// [RULE9] occupied station count accepts only one or four
// [RULE10] own station number accepts one to sixty-four
// [RULE11] on link fault incoming data is cleared or held as configured
// [RULE12] a setting enables or disables the ready flag layout
// [RULE13] link bit rate selectable from 156 kbps to 10 Mbps
// [RULE14] master station uses station number zero
// [RULE15] device writes only its outgoing bits and words; incoming is read-only
// [RULE16] 32 bits and 4 words per direction, or 128 bits and 16 words
//
// Decided for this implementation: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "fbsio_regs.svh"
module fbsio_station
  import fbsio_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic link_ok,
  input wire logic link_in_we,
  input wire logic link_in_word,
  input wire logic [3:0] link_in_idx,
  input wire logic [15:0] link_in_data,
  input wire logic link_out_word,
  input wire logic [3:0] link_out_idx,
  output logic [15:0] link_out_data,
  output logic link_out_tick,
  output logic station_ready,
  output logic [6:0] station_no,
  output logic station_four
);
  // ----------------------------------------
  // configuration and state
  // ----------------------------------------
  logic [2:0] cnt_q;
  logic [6:0] stn_q;
  logic [2:0] baud_q;
  logic hold_q;
  logic rdy_en_q;
  logic online_q;
  fbsio_state_t st_q;
  logic [7:0] init_q;
  logic four;
  logic [2:0] last_bit;
  logic [3:0] last_wrd;
  logic ready;
  logic [15:0] obits_q [8];
  logic [15:0] owrds_q [16];
  logic [15:0] ibits_q [8];
  logic [15:0] iwrds_q [16];
  logic [15:0] in_masked;
  logic [15:0] out_masked;
  logic [15:0] out_sel;
  logic ack_q;
  logic [31:0] rdat_q;
  logic [31:0] rdat_d;
  logic req;
  logic wr;
  logic ctrl_wr;
  logic [2:0] new_cnt;
  logic [6:0] new_stn;
  logic [2:0] new_baud;
  logic in_clear;

  assign four = (cnt_q == 3'h4);
  assign last_bit = four ? `FBSIO_LAST_BIT4 : `FBSIO_LAST_BIT1; // [RULE1]
  assign last_wrd = four ? `FBSIO_LAST_WRD4 : `FBSIO_LAST_WRD1; // [RULE7] [RULE8] [RULE16]
  assign req = wb_cyc_i && wb_stb_i && !ack_q;
  assign wr = req && wb_we_i;
  assign ctrl_wr = wr && (wb_adr_i == `FBSIO_ADR_CTRL) && (wb_sel_i == 4'hF);
  assign new_cnt = wb_dat_i[`FBSIO_F_CNT];
  assign new_stn = wb_dat_i[`FBSIO_F_STN];
  assign new_baud = wb_dat_i[`FBSIO_F_BAUD];

  // ----------------------------------------
  // control register
  // ----------------------------------------
  // illegal values are dropped field by field so a bad write cannot break the map
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= `FBSIO_RST_CNT;
      stn_q <= `FBSIO_RST_STN;
      baud_q <= `FBSIO_RST_BAUD;
      hold_q <= `FBSIO_RST_HOLD;
      rdy_en_q <= `FBSIO_RST_RDYEN;
      online_q <= `FBSIO_RST_ONLINE;
    end else if (ctrl_wr) begin
      if (new_cnt == 3'h1 || new_cnt == 3'h4) begin
        cnt_q <= new_cnt; // [RULE9]
      end
      if (new_stn != 7'h00 && new_stn <= `FBSIO_STN_MAX) begin
        stn_q <= new_stn; // [RULE10]
      end
      if (new_baud <= 3'(BAUD_10M)) begin
        baud_q <= new_baud; // [RULE13]
      end
      hold_q <= wb_dat_i[`FBSIO_F_HOLD]; // [RULE11]
      rdy_en_q <= wb_dat_i[`FBSIO_F_RDYEN]; // [RULE12]
      online_q <= wb_dat_i[`FBSIO_F_ONLINE];
    end
  end

  // ----------------------------------------
  // start-up and operating state
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= ST_INIT;
      init_q <= `FBSIO_INIT_CYC;
    end else begin
      case (st_q)
        ST_INIT: begin
          init_q <= init_q - 8'h01;
          if (init_q == 8'h00) begin
            st_q <= online_q ? ST_ONLINE : ST_OFFLINE; // [RULE4]
          end
        end
        ST_OFFLINE: begin
          if (online_q) begin
            st_q <= ST_ONLINE;
          end
        end
        ST_ONLINE: begin
          if (!online_q) begin
            st_q <= ST_OFFLINE; // [RULE5]
          end
        end
        default: st_q <= ST_INIT;
      endcase
    end
  end

  assign ready = (st_q == ST_ONLINE); // [RULE5]
  assign station_ready = rdy_en_q && ready; // [RULE3] [RULE4]
  assign station_no = stn_q;
  assign station_four = four;

  // ----------------------------------------
  // outgoing images, written by software only
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 8; i++) begin
        obits_q[i] <= 16'h0000;
      end
    end else if (wr && wb_adr_i[7:5] == `FBSIO_ADR_OBIT && wb_adr_i[4:2] <= last_bit) begin
      if (wb_sel_i[0]) begin
        obits_q[wb_adr_i[4:2]][7:0] <= wb_dat_i[7:0]; // [RULE15]
      end
      if (wb_sel_i[1]) begin
        obits_q[wb_adr_i[4:2]][15:8] <= wb_dat_i[15:8];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 16; i++) begin
        owrds_q[i] <= 16'h0000;
      end
    end else if (wr && wb_adr_i[7:6] == `FBSIO_ADR_OWRD && wb_adr_i[5:2] <= last_wrd) begin
      if (wb_sel_i[0]) begin
        owrds_q[wb_adr_i[5:2]][7:0] <= wb_dat_i[7:0]; // [RULE7] [RULE15]
      end
      if (wb_sel_i[1]) begin
        owrds_q[wb_adr_i[5:2]][15:8] <= wb_dat_i[15:8];
      end
    end
  end

  // ----------------------------------------
  // incoming images, written by the link only
  // ----------------------------------------
  assign in_clear = !link_ok && !hold_q; // [RULE11]

  fbsio_bitmask u_in_mask (
    .word_idx(link_in_idx[2:0]),
    .last_idx(last_bit),
    .outgoing(1'b0),
    .ready_en(rdy_en_q),
    .ready(1'b0),
    .din(link_in_data),
    .dout(in_masked)
  );

  for (genvar g = 0; g < 16; g++) begin : g_in
    if (g < 8) begin : g_bit
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          ibits_q[g] <= 16'h0000;
        end else if (in_clear) begin
          ibits_q[g] <= 16'h0000; // [RULE11]
        end else if (link_ok && link_in_we && !link_in_word && link_in_idx == 4'(g)) begin
          ibits_q[g] <= in_masked; // [RULE1] [RULE2]
        end
      end
    end
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        iwrds_q[g] <= 16'h0000;
      end else if (in_clear) begin
        iwrds_q[g] <= 16'h0000; // [RULE11]
      end else if (link_ok && link_in_we && link_in_word && link_in_idx == 4'(g) && 4'(g) <= last_wrd) begin
        iwrds_q[g] <= link_in_data; // [RULE8]
      end
    end
  end

  // ----------------------------------------
  // link output path, paced by the bit rate
  // ----------------------------------------
  fbsio_baud u_baud (
    .clk(clk),
    .rst_n(rst_n),
    .baud_code(baud_q),
    .tick(link_out_tick)
  );

  fbsio_bitmask u_out_mask (
    .word_idx(link_out_idx[2:0]),
    .last_idx(last_bit),
    .outgoing(1'b1),
    .ready_en(rdy_en_q),
    .ready(station_ready),
    .din(obits_q[link_out_idx[2:0]]),
    .dout(out_masked)
  );

  always_comb begin
    out_sel = 16'h0000;
    if (link_out_word) begin
      if (link_out_idx <= last_wrd) begin
        out_sel = owrds_q[link_out_idx]; // [RULE7]
      end
    end else if (!link_out_idx[3]) begin
      out_sel = out_masked; // [RULE2] [RULE3]
    end
  end

  // sampled on the tick so the word stays stable for one bit time
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      link_out_data <= 16'h0000;
    end else if (link_out_tick) begin
      link_out_data <= out_sel;
    end
  end

  // ----------------------------------------
  // wishbone read path
  // ----------------------------------------
  always_comb begin
    rdat_d = 32'h0000_0000;
    if (wb_adr_i == `FBSIO_ADR_CTRL) begin
      rdat_d[`FBSIO_F_CNT] = cnt_q;
      rdat_d[`FBSIO_F_STN] = stn_q;
      rdat_d[`FBSIO_F_BAUD] = baud_q;
      rdat_d[`FBSIO_F_HOLD] = hold_q;
      rdat_d[`FBSIO_F_RDYEN] = rdy_en_q;
      rdat_d[`FBSIO_F_ONLINE] = online_q;
    end else if (wb_adr_i == `FBSIO_ADR_STAT) begin
      rdat_d[3:0] = {link_ok, st_q == ST_INIT, ready, station_ready};
    end else if (wb_adr_i[7:5] == `FBSIO_ADR_OBIT) begin
      rdat_d[15:0] = obits_q[wb_adr_i[4:2]];
    end else if (wb_adr_i[7:5] == `FBSIO_ADR_IBIT) begin
      rdat_d[15:0] = ibits_q[wb_adr_i[4:2]];
    end else if (wb_adr_i[7:6] == `FBSIO_ADR_OWRD) begin
      rdat_d[15:0] = owrds_q[wb_adr_i[5:2]];
    end else if (wb_adr_i[7:6] == `FBSIO_ADR_IWRD) begin
      rdat_d[15:0] = iwrds_q[wb_adr_i[5:2]];
    end
  end

  // every access is answered one cycle later; unmapped reads give zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_q <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end else begin
      ack_q <= req;
      if (req && !wb_we_i) begin
        rdat_q <= rdat_d;
      end
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_init_done;
    st_q == ST_INIT && init_q == 8'h00;
  endsequence

  AST_READY_LOW_NOT_ONLINE: assert property ( // [RULE5]
    st_q != ST_ONLINE |-> !station_ready)
    else $error("ready flag high outside online state");

  AST_READY_AFTER_INIT: assert property ( // [RULE4]
    s_init_done ##0 (online_q && rdy_en_q && !ctrl_wr) |=> station_ready)
    else $error("ready flag missing after start-up");

  AST_COUNT_LEGAL: assert property ( // [RULE9]
    cnt_q == 3'h1 || cnt_q == 3'h4)
    else $error("occupied station count illegal");

  AST_STATION_RANGE: assert property ( // [RULE10]
    stn_q >= 7'h01 && stn_q <= `FBSIO_STN_MAX)
    else $error("station number out of range");

  AST_CLEAR_ON_FAULT: assert property ( // [RULE11]
    (!link_ok && !hold_q) |=> (ibits_q[0] == 16'h0000 && iwrds_q[0] == 16'h0000))
    else $error("incoming data not cleared on link fault");

  AST_HOLD_ON_FAULT: assert property ( // [RULE11]
    (!link_ok && hold_q && !ctrl_wr) |=> $stable(iwrds_q[0]))
    else $error("incoming data changed while held");

  AST_OUT_RESERVED: assert property ( // [RULE2]
    (link_out_tick && !link_out_word && link_out_idx == {1'b0, last_bit} && !rdy_en_q)
    |=> link_out_data[15:14] == 2'h0)
    else $error("reserved outgoing bits driven");

  AST_OUT_READY_BIT: assert property ( // [RULE3]
    (link_out_tick && !link_out_word && link_out_idx == {1'b0, last_bit} && rdy_en_q)
    |=> link_out_data == ($past(station_ready) ? 16'h0800 : 16'h0000))
    else $error("ready flag word malformed");

  AST_OUT_WORD_RANGE: assert property ( // [RULE7]
    (link_out_tick && link_out_word && link_out_idx > last_wrd) |=> link_out_data == 16'h0000)
    else $error("word beyond area sent");

  AST_WB_ACK_PULSE: assert property ( // wishbone handshake, decided for this implementation
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held for two cycles");
endmodule

// ---- pkg/fbsio_regs.svh ----
// register offsets, field positions, reset values and timing counts
`ifndef FBSIO_REGS_SVH
`define FBSIO_REGS_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define FBSIO_ADR_CTRL 8'h00
`define FBSIO_ADR_STAT 8'h04
`define FBSIO_ADR_OBIT 3'h2
`define FBSIO_ADR_IBIT 3'h3
`define FBSIO_ADR_OWRD 2'h2
`define FBSIO_ADR_IWRD 2'h3

// ----------------------------------------
// control fields
// ----------------------------------------
`define FBSIO_F_CNT 2:0
`define FBSIO_F_STN 10:4
`define FBSIO_F_BAUD 14:12
`define FBSIO_F_HOLD 16
`define FBSIO_F_RDYEN 17
`define FBSIO_F_ONLINE 18

// ----------------------------------------
// reset values and limits
// ----------------------------------------
`define FBSIO_RST_CNT 3'h1
`define FBSIO_RST_STN 7'h01
`define FBSIO_STN_MAX 7'h40
`define FBSIO_RST_BAUD 3'h0
`define FBSIO_RST_HOLD 1'h0
`define FBSIO_RST_RDYEN 1'h1
`define FBSIO_RST_ONLINE 1'h1
`define FBSIO_LAST_BIT1 3'h1
`define FBSIO_LAST_BIT4 3'h7
`define FBSIO_LAST_WRD1 4'h3
`define FBSIO_LAST_WRD4 4'hF
`define FBSIO_RDY_BIT 11

// ----------------------------------------
// timing
// ----------------------------------------
`define FBSIO_CLK_HZ 40000000
`define FBSIO_INIT_CYC 8'h10
`define FBSIO_DIV_156K (`FBSIO_CLK_HZ / 156000)
`define FBSIO_DIV_625K (`FBSIO_CLK_HZ / 625000)
`define FBSIO_DIV_2M5 (`FBSIO_CLK_HZ / 2500000)
`define FBSIO_DIV_5M (`FBSIO_CLK_HZ / 5000000)
`define FBSIO_DIV_10M (`FBSIO_CLK_HZ / 10000000)

`endif

// ---- pkg/fbsio_pkg.sv ----
// types shared by the station map block
package fbsio_pkg;
  typedef enum logic [1:0] {
    ST_INIT,
    ST_OFFLINE,
    ST_ONLINE
  } fbsio_state_t;

  typedef enum logic [2:0] {
    BAUD_156K,
    BAUD_625K,
    BAUD_2M5,
    BAUD_5M,
    BAUD_10M
  } fbsio_baud_t;
endpackage

// ---- core/fbsio_bitmask.sv ----
// reserved-bit masking for one remote bit word
`timescale 1ns/1ps
`include "fbsio_regs.svh"
module fbsio_bitmask
  import fbsio_pkg::*;
(
  input wire logic [2:0] word_idx,
  input wire logic [2:0] last_idx,
  input wire logic outgoing,
  input wire logic ready_en,
  input wire logic ready,
  input wire logic [15:0] din,
  output logic [15:0] dout
);
  always_comb begin
    dout = din;
    if (word_idx > last_idx) begin
      dout = 16'h0000; // [RULE1]
    end else if (word_idx == last_idx) begin
      if (!ready_en) begin
        dout = {2'h0, din[13:0]}; // [RULE2]
      end else begin
        dout = 16'h0000; // [RULE3]
        if (outgoing) begin
          dout[`FBSIO_RDY_BIT] = ready; // [RULE3]
        end
      end
    end
  end
endmodule

// ---- core/fbsio_baud.sv ----
// link bit-rate tick generator
`timescale 1ns/1ps
`include "fbsio_regs.svh"
module fbsio_baud
  import fbsio_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [2:0] baud_code,
  output logic tick
);
  logic [8:0] div;
  logic [8:0] cnt_q;
  logic [8:0] cnt_d;

  always_comb begin
    case (fbsio_baud_t'(baud_code))
      BAUD_625K: div = 9'(`FBSIO_DIV_625K); // [RULE13]
      BAUD_2M5: div = 9'(`FBSIO_DIV_2M5);
      BAUD_5M: div = 9'(`FBSIO_DIV_5M);
      BAUD_10M: div = 9'(`FBSIO_DIV_10M);
      default: div = 9'(`FBSIO_DIV_156K);
    endcase
  end

  always_comb begin
    cnt_d = cnt_q + 9'h001;
    if (cnt_q >= div - 9'h001) begin
      cnt_d = 9'h000;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 9'h000;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign tick = (cnt_q == 9'h000);

  AST_BAUD_GAP: assert property (@(posedge clk) disable iff (!rst_n) // [RULE13]
    tick |=> !tick [*3])
    else $error("baud tick repeated too soon");
endmodule

// ---- bench/fbsio_master_model.sv ----
// fieldbus master model facing the station link side
`timescale 1ns/1ps
module fbsio_master_model #(
  parameter logic [6:0] MASTER_STN = 7'h00 // master sits at station zero
) (
  input wire logic clk,
  input wire logic interlock,
  input wire logic station_ready,
  input wire logic link_out_tick,
  input wire logic [15:0] link_out_data,
  output logic link_ok,
  output logic link_in_we,
  output logic link_in_word,
  output logic [3:0] link_in_idx,
  output logic [15:0] link_in_data,
  output logic link_out_word,
  output logic [3:0] link_out_idx
);
  // ----------------
  // idle levels
  // ----------------
  initial begin
    link_ok = 1'h1;
    link_in_we = 1'h0;
    link_in_word = 1'h0;
    link_in_idx = 4'h0;
    link_in_data = 16'h0000;
    link_out_word = 1'h0;
    link_out_idx = 4'h0;
  end
  // ----------------
  // link tasks
  // ----------------
  task automatic set_link(input logic v);
    @(posedge clk);
    link_ok <= v;
  endtask
  // only the station's incoming images are written
  task automatic put(input logic w, input logic [3:0] i, input logic [15:0] d);
    int n;
    n = 0;
    while (interlock && station_ready !== 1'h1 && n < 100) begin // wait for ready
      @(posedge clk);
      n++;
    end
    @(posedge clk);
    link_in_we <= 1'h1;
    link_in_word <= w;
    link_in_idx <= i;
    link_in_data <= d;
    @(posedge clk);
    link_in_we <= 1'h0;
    // stale data must not look valid
    link_in_data <= ~d;
  endtask
  // select ahead of the tick, take the word one edge after it
  task automatic get(input logic w, input logic [3:0] i, output logic [15:0] d);
    int n;
    n = 0;
    @(posedge clk);
    link_out_word <= w;
    link_out_idx <= i;
    do begin
      @(posedge clk);
      n++;
    end while (link_out_tick !== 1'h1 && n < 600);
    @(posedge clk);
    d = link_out_data;
  endtask
endmodule

// ---- bench/fbsio_station_tb.sv ----
// self-checking bench for the station map block
`timescale 1ns/1ps
module fbsio_station_tb;
  logic clk, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, link_ok, link_in_we, link_in_word;
  logic link_out_word, link_out_tick, station_ready, station_four, interlock;
  logic [3:0] wb_sel_i, link_in_idx, link_out_idx;
  logic [7:0] wb_adr_i;
  logic [31:0] wb_dat_i, wb_dat_o, q;
  logic [15:0] link_in_data, link_out_data, od;
  logic [6:0] station_no;
  int fails, tests_run, cycles, p;
  int per[5] = '{256, 64, 16, 8, 4};

  fbsio_station u_fbsio_station (
    .clk(clk),
    .rst_n(rst_n),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .link_ok(link_ok),
    .link_in_we(link_in_we),
    .link_in_word(link_in_word),
    .link_in_idx(link_in_idx),
    .link_in_data(link_in_data),
    .link_out_word(link_out_word),
    .link_out_idx(link_out_idx),
    .link_out_data(link_out_data),
    .link_out_tick(link_out_tick),
    .station_ready(station_ready),
    .station_no(station_no),
    .station_four(station_four)
  );
  fbsio_master_model u_fbsio_master_model (
    .clk(clk),
    .interlock(interlock),
    .station_ready(station_ready),
    .link_out_tick(link_out_tick),
    .link_out_data(link_out_data),
    .link_ok(link_ok),
    .link_in_we(link_in_we),
    .link_in_word(link_in_word),
    .link_in_idx(link_in_idx),
    .link_in_data(link_in_data),
    .link_out_word(link_out_word),
    .link_out_idx(link_out_idx)
  );

  // ----------------
  // helpers
  // ----------------
  function automatic logic [31:0] ctrl(input int c, s, b, h, r, o);
    return {13'h0, o[0], r[0], h[0], 1'h0, b[2:0], 1'h0, s[6:0], 1'h0, c[2:0]};
  endfunction
  task automatic check(input string nm, input logic [31:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // classic cycle: hold everything until ack is sampled
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge clk);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= s;
    // no latency assumed; only the bench timeout ends a stuck wait
    do @(posedge clk); while (wb_ack_o !== 1'h1);
    q = wb_dat_o;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
    wb_we_i <= 1'h0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'h1, a, d, 4'hF);
  endtask
  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
    wb(1'h0, a, 32'h0, 4'hF);
    check(nm, q, e);
  endtask
  task automatic wait_ready;
    for (int n = 0; n < 40 && station_ready !== 1'h1; n++) @(posedge clk);
  endtask
  task automatic period(output int t);
    t = 0;
    do @(posedge clk); while (link_out_tick !== 1'h1);
    do begin
      @(posedge clk);
      t++;
    end while (link_out_tick !== 1'h1 && t < 600);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ----------------
  // clock, timeout, sequence
  // ----------------
  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      tally_and_finish();
    end
  end

  initial begin
    clk = 1'h0;
    rst_n = 1'h0;
    wb_cyc_i = 1'h0;
    wb_stb_i = 1'h0;
    wb_we_i = 1'h0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0;
    interlock = 1'h1;
    fails = 0;
    tests_run = 0;
    cycles = 0;
    repeat (3) @(posedge clk);
    rst_n <= 1'h1;
    repeat (2) @(posedge clk);
    check("ready_init", station_ready, 1'h0);
    repeat (20) @(posedge clk);
    check("ready_up", station_ready, 1'h1);
    check("stn_rst", station_no, 7'h01);
    rd("ctrl_rst", 8'h00, ctrl(1, 1, 0, 0, 1, 1));
    rd("stat", 8'h04, 32'h0000000B);
    rd("unmapped", 8'h20, 32'h0);
    // one station: indices past the area are dropped
    u_fbsio_master_model.put(1'h1, 4'h4, 16'h1111);
    u_fbsio_master_model.put(1'h0, 4'h2, 16'h2222);
    wr(8'h00, ctrl(2, 65, 5, 1, 1, 1));
    rd("ctrl_bad", 8'h00, ctrl(1, 1, 0, 1, 1, 1));
    wr(8'h00, ctrl(1, 0, 0, 1, 1, 1));
    check("stn0", station_no, 7'h01);
    wb(1'h1, 8'h00, ctrl(4, 64, 4, 0, 0, 1), 4'h3);
    rd("ctrl_sel", 8'h00, ctrl(1, 1, 0, 1, 1, 1));
    wr(8'h00, ctrl(4, 64, 4, 0, 0, 1));
    check("four", station_four, 1'h1);
    check("stn64", station_no, 7'h40);
    check("rdy_off", station_ready, 1'h0);
    rd("in_w4", 8'hD0, 32'h0);
    rd("in_b2", 8'h68, 32'h0);
    // flag unused, so the master cannot interlock
    interlock <= 1'h0;
    u_fbsio_master_model.put(1'h0, 4'h6, 16'hFFFF);
    u_fbsio_master_model.put(1'h0, 4'h7, 16'hFFFF);
    u_fbsio_master_model.put(1'h1, 4'hF, 16'hBEEF);
    rd("in_b6", 8'h78, 32'h0000FFFF);
    rd("in_b7", 8'h7C, 32'h00003FFF);
    rd("in_w15", 8'hFC, 32'h0000BEEF);
    wr(8'h5C, 32'h0000FFFF);
    wr(8'hBC, 32'h00001234);
    u_fbsio_master_model.get(1'h0, 4'h7, od);
    check("out_b7", od, 16'h3FFF);
    u_fbsio_master_model.get(1'h1, 4'hF, od);
    check("out_w15", od, 16'h1234);
    wr(8'hFC, 32'h0);
    rd("ro_in", 8'hFC, 32'h0000BEEF);
    wr(8'h04, 32'hFFFFFFFF);
    wr(8'h00, ctrl(4, 5, 4, 0, 1, 1));
    interlock <= 1'h1;
    wait_ready();
    check("rdy_on", station_ready, 1'h1);
    u_fbsio_master_model.get(1'h0, 4'h7, od);
    check("out_flag", od, 16'h0800);
    u_fbsio_master_model.put(1'h0, 4'h7, 16'hFFFF);
    rd("in_b7r", 8'h7C, 32'h0);
    rd("stat_ro", 8'h04, 32'h0000000B);
    wr(8'h00, ctrl(4, 5, 4, 0, 1, 0));
    @(posedge clk);
    check("offline", station_ready, 1'h0);
    wr(8'h00, ctrl(4, 5, 4, 0, 1, 1));
    wait_ready();
    check("online", station_ready, 1'h1);
    // link fault, clear then hold
    u_fbsio_master_model.put(1'h1, 4'h0, 16'hA5A5);
    u_fbsio_master_model.set_link(1'h0);
    repeat (3) @(posedge clk);
    u_fbsio_master_model.set_link(1'h1);
    rd("in_clr", 8'hC0, 32'h0);
    wr(8'h00, ctrl(4, 5, 4, 1, 1, 1));
    u_fbsio_master_model.put(1'h1, 4'h0, 16'hA5A5);
    u_fbsio_master_model.set_link(1'h0);
    rd("stat_down", 8'h04, 32'h00000003);
    u_fbsio_master_model.put(1'h1, 4'h1, 16'h7777);
    u_fbsio_master_model.set_link(1'h1);
    rd("in_hold", 8'hC0, 32'h0000A5A5);
    rd("in_down", 8'hC4, 32'h0);
    // word 4 exists only with four stations
    wr(8'h90, 32'h00005A5A);
    rd("out_w4", 8'h90, 32'h00005A5A);
    wr(8'h00, ctrl(1, 5, 4, 1, 1, 1));
    u_fbsio_master_model.get(1'h1, 4'h4, od);
    check("out_w4_gone", od, 16'h0);
    // mid-run hardware reset: flag drops, then returns after start-up
    @(posedge clk);
    rst_n <= 1'h0;
    repeat (3) @(posedge clk);
    rst_n <= 1'h1;
    @(posedge clk);
    check("rst_ready", station_ready, 1'h0);
    rd("rst_in", 8'hC0, 32'h0);
    wait_ready();
    check("rst_up", station_ready, 1'h1);
    for (int b = 0; b < 5; b++) begin
      wr(8'h00, ctrl(4, 5, b, 1, 1, 1));
      period(p);
      check("tick_period", p, per[b]);
    end
    tally_and_finish();
  end
endmodule
